// *** hdl/dwd_write_decoder.sv ***
// Write decoder for a 40-channel DAC: selects groups and registers
// Assumes one write word per cycle when wr_valid_i is high
// Functional notes
// - Select bits route data to register kind
// - Input code is straight binary
// - Offset code is offset binary
// - Gain code G means (G+1)/16384
// - Special write steps input codes
// - All-ones special write is soft reset
// - Eight-bit address accompanies every write
// - Zero group nibble writes all 40 channels
// - Low nibble picks register 0 to 9
// - Bit 8 direction, bits 6:0 magnitude
// - Step results clamp, never wrap
// - Reset restores power-on values, outputs to ground
module dwd_write_decoder
    import dwd_pkg::*;
#(
    parameter int CHANNELS = DWD_CHANNELS
)
(
    input  wire logic                           clk_i,
    input  wire logic                           rst_i,
    input  wire logic                           wr_valid_i,
    input  wire logic                           dest_select_hi_i,
    input  wire logic                           dest_select_lo_i,
    input  wire logic [DWD_DATA_W-1:0]          write_data_field_i,
    input  wire logic [DWD_ADDR_W-1:0]          channel_address_field_i,
    input  wire logic                           output_load_strobe_i,
    output logic [CHANNELS*DWD_DATA_W-1:0]      channel_input_code_o,
    output logic [CHANNELS*DWD_DATA_W-1:0]      channel_offset_value_o,
    output logic [CHANNELS*DWD_DATA_W-1:0]      channel_gain_value_o,
    output logic                                reference_ground_level_o
);
    // Elaboration check on the channel count
    if (CHANNELS != DWD_CHANNELS) begin : g_bad_channels
        $error("CHANNELS must equal 40");
    end

    typedef struct packed {
        logic [CHANNELS*DWD_DATA_W-1:0] input_code;
        logic [CHANNELS*DWD_DATA_W-1:0] offset_value;
        logic [CHANNELS*DWD_DATA_W-1:0] gain_value;
        logic                           at_ground;
    } dwd_state_t;

    dwd_state_t          st_ff;
    dwd_state_t          nxt_st;
    logic [1:0]          sel;
    logic [3:0]          grp;
    logic [3:0]          idx;
    logic                soft_rst;
    logic [CHANNELS-1:0] hit;
    logic [DWD_DATA_W-1:0] ch_input  [CHANNELS];
    logic [DWD_DATA_W-1:0] ch_offset [CHANNELS];
    logic [DWD_DATA_W-1:0] ch_gain   [CHANNELS];

    // =========================================================
    // Address and command decode
    assign sel      = {dest_select_hi_i, dest_select_lo_i};
    assign grp      = channel_address_field_i[DWD_ADDR_W-1:DWD_GRP_LSB];
    assign idx      = channel_address_field_i[DWD_IDX_W-1:0];
    assign soft_rst = wr_valid_i && sel == DWD_SEL_SPEC
                      && write_data_field_i == DWD_SOFT_RESET;

    // =========================================================
    // Channel slices
    for (genvar g = 0; g < CHANNELS; g++) begin : g_ch
        dwd_chan_if cif ();
        // Channel g sits in group g/10 at register g%10
        assign hit[g] = wr_valid_i && ((grp == 4'h0)
                        || (grp[g/DWD_PER_GROUP] && idx == 4'(g % DWD_PER_GROUP)));
        assign cif.hit        = hit[g];
        assign cif.sel        = sel;
        assign cif.data       = write_data_field_i;
        assign cif.soft_reset = soft_rst;
        dwd_channel u_ch (
            .clk_i (clk_i),
            .rst_i (rst_i),
            .bus   (cif.chn)
        );
        assign ch_input[g]  = cif.input_code;
        assign ch_offset[g] = cif.offset_value;
        assign ch_gain[g]   = cif.gain_value;
    end

    // =========================================================
    // Output stage and ground hold until load strobe
    always_comb begin
        nxt_st = st_ff;
        for (int k = 0; k < CHANNELS; k++) begin
            nxt_st.input_code[k*DWD_DATA_W +: DWD_DATA_W]   = ch_input[k];
            nxt_st.offset_value[k*DWD_DATA_W +: DWD_DATA_W] = ch_offset[k];
            nxt_st.gain_value[k*DWD_DATA_W +: DWD_DATA_W]   = ch_gain[k];
        end
        if (soft_rst) begin
            nxt_st.at_ground = 1'b1;
        end else if (output_load_strobe_i) begin
            nxt_st.at_ground = 1'b0;
        end else begin
            nxt_st.at_ground = st_ff.at_ground;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_ff.input_code   <= {CHANNELS{DWD_INPUT_RST}};
            st_ff.offset_value <= {CHANNELS{DWD_OFFSET_RST}};
            st_ff.gain_value   <= {CHANNELS{DWD_GAIN_RST}};
            st_ff.at_ground    <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign channel_input_code_o   = st_ff.input_code;
    assign channel_offset_value_o = st_ff.offset_value;
    assign channel_gain_value_o   = st_ff.gain_value;
    assign reference_ground_level_o = st_ff.at_ground;

    // =========================================================
    // Checks
    a_soft_rst_gnd: assert property (@(posedge clk_i) disable iff (rst_i)
        soft_rst |=> reference_ground_level_o)
        else $error("soft reset did not force reference ground");
    a_broadcast_hit: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr_valid_i && grp == 4'h0) |-> (&hit))
        else $error("broadcast write missed a channel");
    a_group_sel: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr_valid_i && grp == 4'h2 && idx == 4'h3) |-> (hit == 40'h00_0000_2000))
        else $error("group decode wrong");
    a_input_load: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr_valid_i && sel == DWD_SEL_INPUT && grp == 4'h1 && idx == 4'h0)
        |=> ##1 channel_input_code_o[DWD_DATA_W-1:0] == $past(write_data_field_i, 2))
        else $error("input code not loaded");
    a_gain_load: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr_valid_i && sel == DWD_SEL_GAIN && grp == 4'h8 && idx == 4'h9)
        |=> ##1 channel_gain_value_o[39*DWD_DATA_W +: DWD_DATA_W] == $past(write_data_field_i, 2))
        else $error("gain not loaded");
    a_load_release: assert property (@(posedge clk_i) disable iff (rst_i)
        (output_load_strobe_i && !soft_rst) |=> !reference_ground_level_o)
        else $error("load strobe did not release ground");
    a_ground_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        (!soft_rst && !output_load_strobe_i) |=> $stable(reference_ground_level_o))
        else $error("ground flag moved without soft reset or load");
    a_soft_rst_regs: assert property (@(posedge clk_i) disable iff (rst_i)
        soft_rst
        |=> ##1 channel_input_code_o == {CHANNELS{DWD_INPUT_RST}}
                && channel_offset_value_o == {CHANNELS{DWD_OFFSET_RST}}
                && channel_gain_value_o == {CHANNELS{DWD_GAIN_RST}})
        else $error("soft reset did not restore channel registers");

    // =========================================================
    // Decode checks
    a_idle_no_hit: assert property (@(posedge clk_i) disable iff (rst_i)
        !wr_valid_i |-> hit == '0)
        else $error("channel hit without a write");
    a_hit_count: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr_valid_i && grp != 4'h0 && idx < 4'(DWD_PER_GROUP))
        |-> $countones(hit) == $countones(grp))
        else $error("hit count differs from selected groups");
    a_offset_load: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr_valid_i && sel == DWD_SEL_OFFSET && grp == 4'h4 && idx == 4'h5)
        |=> ##1 channel_offset_value_o[25*DWD_DATA_W +: DWD_DATA_W]
                == $past(write_data_field_i, 2))
        else $error("offset not loaded");
    a_bcast_gain: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr_valid_i && sel == DWD_SEL_GAIN && grp == 4'h0)
        |=> ##1 channel_gain_value_o == {CHANNELS{$past(write_data_field_i, 2)}})
        else $error("broadcast gain not loaded everywhere");
endmodule

// *** hdl/dwd_pkg.sv ***
// Constants for the write decoder of a 40-channel DAC
// Assumes one decoded write word per clock from the front end
package dwd_pkg;
    localparam int DWD_DATA_W     = 14;
    localparam int DWD_ADDR_W     = 8;
    localparam int DWD_GROUPS     = 4;
    localparam int DWD_PER_GROUP  = 10;
    localparam int DWD_CHANNELS   = DWD_GROUPS * DWD_PER_GROUP;
    localparam int DWD_IDX_W      = 4;
    localparam int DWD_CH_W       = 6;
    // Destination select codes
    localparam logic [1:0] DWD_SEL_INPUT  = 2'h3;
    localparam logic [1:0] DWD_SEL_OFFSET = 2'h2;
    localparam logic [1:0] DWD_SEL_GAIN   = 2'h1;
    localparam logic [1:0] DWD_SEL_SPEC   = 2'h0;
    // Field positions
    localparam int DWD_DIR_BIT    = 8;
    localparam int DWD_MAG_W      = 7;
    localparam int DWD_GRP_LSB    = 4;
    // Reset values and codes
    localparam logic [13:0] DWD_SOFT_RESET  = 14'h3fff;
    localparam logic [13:0] DWD_FULL_SCALE  = 14'h3fff;
    localparam logic [13:0] DWD_ZERO_SCALE  = 14'h0000;
    localparam logic [13:0] DWD_INPUT_RST   = 14'h0000;
    localparam logic [13:0] DWD_OFFSET_RST  = 14'h2000;
    localparam logic [13:0] DWD_GAIN_RST    = 14'h3fff;
endpackage

// *** hdl/dwd_chan_if.sv ***
// Per-channel update bundle between the decoder and a channel slice
// Assumes both ends on the same clock
interface dwd_chan_if;
    import dwd_pkg::*;
    logic                  hit;
    logic [1:0]            sel;
    logic [DWD_DATA_W-1:0] data;
    logic                  soft_reset;
    logic [DWD_DATA_W-1:0] input_code;
    logic [DWD_DATA_W-1:0] offset_value;
    logic [DWD_DATA_W-1:0] gain_value;
    modport dec (output hit, sel, data, soft_reset,
                 input  input_code, offset_value, gain_value);
    modport chn (input  hit, sel, data, soft_reset,
                 output input_code, offset_value, gain_value);
endinterface

// *** hdl/dwd_channel.sv ***
// One channel: input, offset and gain registers with step logic
// Assumes decoded write strobe from the decoder, synchronous reset
module dwd_channel
    import dwd_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic rst_i,
    dwd_chan_if.chn   bus
);
    typedef struct packed {
        logic [DWD_DATA_W-1:0] input_code;
        logic [DWD_DATA_W-1:0] offset_value;
        logic [DWD_DATA_W-1:0] gain_value;
    } dwd_ch_state_t;

    dwd_ch_state_t         cur_ff;
    dwd_ch_state_t         nxt_ch;
    logic [DWD_DATA_W:0]   step_sum;

    // =========================================================
    // Update
    always_comb begin
        nxt_ch   = cur_ff;
        step_sum = '0;
        if (bus.data[DWD_DIR_BIT]) begin
            step_sum = {1'b0, cur_ff.input_code} + (DWD_DATA_W+1)'(bus.data[DWD_MAG_W-1:0]);
        end else begin
            step_sum = {1'b0, cur_ff.input_code} - (DWD_DATA_W+1)'(bus.data[DWD_MAG_W-1:0]);
        end
        if (bus.hit) begin
            unique case (bus.sel)
                DWD_SEL_INPUT:  nxt_ch.input_code   = bus.data;
                DWD_SEL_OFFSET: nxt_ch.offset_value = bus.data;
                DWD_SEL_GAIN:   nxt_ch.gain_value   = bus.data;
                DWD_SEL_SPEC: begin
                    if (!bus.soft_reset) begin
                        // Clamp at full or zero scale on overflow
                        if (step_sum[DWD_DATA_W] && bus.data[DWD_DIR_BIT]) begin
                            nxt_ch.input_code = DWD_FULL_SCALE;
                        end else if (step_sum[DWD_DATA_W]) begin
                            nxt_ch.input_code = DWD_ZERO_SCALE;
                        end else begin
                            nxt_ch.input_code = step_sum[DWD_DATA_W-1:0];
                        end
                    end
                end
            endcase
        end
        if (bus.soft_reset) begin
            nxt_ch.input_code   = DWD_INPUT_RST;
            nxt_ch.offset_value = DWD_OFFSET_RST;
            nxt_ch.gain_value   = DWD_GAIN_RST;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cur_ff <= '{DWD_INPUT_RST, DWD_OFFSET_RST, DWD_GAIN_RST};
        end else begin
            cur_ff <= nxt_ch;
        end
    end

    assign bus.input_code   = cur_ff.input_code;
    assign bus.offset_value = cur_ff.offset_value;
    assign bus.gain_value   = cur_ff.gain_value;

    a_step_clamp_hi: assert property (@(posedge clk_i) disable iff (rst_i)
        (bus.hit && bus.sel == DWD_SEL_SPEC && !bus.soft_reset && bus.data[DWD_DIR_BIT]
         && {1'b0, cur_ff.input_code} + (DWD_DATA_W+1)'(bus.data[6:0]) > 15'h3fff)
        |=> cur_ff.input_code == DWD_FULL_SCALE)
        else $error("increment did not clamp at full scale");
    a_step_clamp_lo: assert property (@(posedge clk_i) disable iff (rst_i)
        (bus.hit && bus.sel == DWD_SEL_SPEC && !bus.soft_reset && !bus.data[DWD_DIR_BIT]
         && cur_ff.input_code < DWD_DATA_W'(bus.data[6:0]))
        |=> cur_ff.input_code == DWD_ZERO_SCALE)
        else $error("decrement did not clamp at zero scale");
    a_step_inc: assert property (@(posedge clk_i) disable iff (rst_i)
        (bus.hit && bus.sel == DWD_SEL_SPEC && !bus.soft_reset && bus.data[DWD_DIR_BIT]
         && {1'b0, cur_ff.input_code} + (DWD_DATA_W+1)'(bus.data[6:0]) <= 15'h3fff)
        |=> cur_ff.input_code == $past(cur_ff.input_code) + DWD_DATA_W'($past(bus.data[6:0])))
        else $error("increment step wrong");
    a_step_dec: assert property (@(posedge clk_i) disable iff (rst_i)
        (bus.hit && bus.sel == DWD_SEL_SPEC && !bus.soft_reset && !bus.data[DWD_DIR_BIT]
         && cur_ff.input_code >= DWD_DATA_W'(bus.data[6:0]))
        |=> cur_ff.input_code == $past(cur_ff.input_code) - DWD_DATA_W'($past(bus.data[6:0])))
        else $error("decrement step wrong");
    a_route_input: assert property (@(posedge clk_i) disable iff (rst_i)
        (bus.hit && bus.sel == DWD_SEL_INPUT)
        |=> cur_ff.offset_value == $past(cur_ff.offset_value)
            && cur_ff.gain_value == $past(cur_ff.gain_value))
        else $error("input write disturbed offset or gain");
endmodule

// *** verif/dwd_host_model.sv ***
// Host controller model presenting decoded write words
// Assumes the bench clock; drives 1 ns after each rising edge
module dwd_host_model
    import dwd_pkg::*;
(
    input  wire logic                  clk_i,
    output logic                       wr_valid_o,
    output logic [1:0]                 sel_o,
    output logic [DWD_DATA_W-1:0]      data_o,
    output logic [DWD_ADDR_W-1:0]      addr_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        wr_valid_o = 1'b0;
        sel_o      = 2'h0;
        data_o     = 14'h0000;
        addr_o     = 8'h00;
    end
    // ====================
    // One write word, one cycle
    task automatic wr(input logic [1:0] s, input logic [13:0] d, input logic [7:0] a);
        @(posedge clk_i);
        #1;
        wr_valid_o <= 1'b1;
        sel_o      <= s;
        data_o     <= d;
        addr_o     <= a;
        @(posedge clk_i);
        #1;
        wr_valid_o <= 1'b0;
        sel_o      <= ~s;
        data_o     <= ~d;
        addr_o     <= ~a;
    endtask
endmodule

// *** verif/dwd_write_decoder_bench.sv ***
// Self-checking bench for the DAC write decoder
// Assumes host model drives writes; bench owns clock, reset, load
module dwd_write_decoder_bench
    import dwd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int NW = DWD_CHANNELS * DWD_DATA_W;
    logic              clk_i;
    logic              rst_i;
    logic              ld;
    logic              wv;
    logic [1:0]        sel;
    logic [13:0]       wd;
    logic [7:0]        wa;
    logic [NW-1:0]     in_o;
    logic [NW-1:0]     off_o;
    logic [NW-1:0]     gn_o;
    logic              gnd_o;
    logic [13:0]       r_in[DWD_CHANNELS];
    logic [13:0]       r_off[DWD_CHANNELS];
    logic [13:0]       r_gn[DWD_CHANNELS];
    logic              r_gnd;
    int                bad_count;
    int                checked;
    dwd_host_model host (.clk_i(clk_i), .wr_valid_o(wv), .sel_o(sel), .data_o(wd), .addr_o(wa));
    dwd_write_decoder dut (.clk_i(clk_i), .rst_i(rst_i), .wr_valid_i(wv),
        .dest_select_hi_i(sel[1]), .dest_select_lo_i(sel[0]), .write_data_field_i(wd),
        .channel_address_field_i(wa), .output_load_strobe_i(ld), .channel_input_code_o(in_o),
        .channel_offset_value_o(off_o), .channel_gain_value_o(gn_o),
        .reference_ground_level_o(gnd_o));
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    // ====================
    // Expectation helpers
    function automatic logic hit(int k, logic [7:0] a);
        return a[7:4] == 4'h0 || (a[4 + k / 10] && a[3:0] == 4'(k % 10));
    endfunction
    function automatic logic [13:0] step(logic [13:0] v, logic [13:0] d);
        int r;
        r = d[8] ? int'(v) + int'(d[6:0]) : int'(v) - int'(d[6:0]);
        return (r > 16383) ? 14'h3fff : (r < 0) ? 14'h0000 : 14'(r);
    endfunction
    task automatic rst_ref;
        foreach (r_in[k]) begin
            r_in[k]  = DWD_INPUT_RST;
            r_off[k] = DWD_OFFSET_RST;
            r_gn[k]  = DWD_GAIN_RST;
        end
        r_gnd = 1'b1;
    endtask
    task automatic cmp(input logic [13:0] got, input logic [13:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_all;
        for (int k = 0; k < DWD_CHANNELS; k++) begin
            cmp(in_o[k*14+:14], r_in[k]);
            cmp(off_o[k*14+:14], r_off[k]);
            cmp(gn_o[k*14+:14], r_gn[k]);
        end
        cmp({13'h0000, gnd_o}, {13'h0000, r_gnd});
    endtask
    task automatic wr(input logic [1:0] s, input logic [13:0] d, input logic [7:0] a);
        host.wr(s, d, a);
        if (s == DWD_SEL_SPEC && d == DWD_SOFT_RESET) rst_ref();
        else for (int k = 0; k < DWD_CHANNELS; k++) begin
            if (hit(k, a)) begin
                case (s)
                    DWD_SEL_INPUT:  r_in[k]  = d;
                    DWD_SEL_OFFSET: r_off[k] = d;
                    DWD_SEL_GAIN:   r_gn[k]  = d;
                    default:        r_in[k]  = step(r_in[k], d);
                endcase
            end
        end
        repeat (2) @(posedge clk_i);
        #1;
        chk_all();
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // ====================
    // Tests
    initial begin
        logic [13:0] d;
        rst_i = 1'b1;
        ld = 1'b0;
        bad_count = 0;
        checked = 0;
        void'($urandom(32'hf4a8_f3d0));
        rst_ref();
        repeat (8) @(posedge clk_i);
        #1 rst_i = 1'b0;
        chk_all();
        @(posedge clk_i);
        #1 ld = 1'b1;
        @(posedge clk_i);
        #1 ld = 1'b0;
        r_gnd = 1'b0;
        chk_all();
        $display("test reset_load done");
        for (int i = 0; i < 200; i++) begin
            d = 14'($urandom);
            wr(2'(1 + $urandom % 3), d, {4'($urandom), 4'($urandom % 10)});
        end
        wr(DWD_SEL_INPUT, 14'h1a5c, 8'h10);
        wr(DWD_SEL_GAIN, 14'h0c33, 8'h89);
        wr(DWD_SEL_OFFSET, 14'h2001, 8'h45);
        wr(DWD_SEL_GAIN, 14'h1fff, 8'h00);
        wr(DWD_SEL_OFFSET, 14'h0001, 8'h23);
        $display("test direct_writes done");
        wr(DWD_SEL_INPUT, 14'h3f90, 8'h00);
        wr(DWD_SEL_SPEC, 14'h017f, 8'h00);
        wr(DWD_SEL_INPUT, 14'h0005, 8'hf3);
        wr(DWD_SEL_SPEC, 14'h007f, 8'hf3);
        for (int i = 0; i < 100; i++) begin
            d = {5'h00, 9'($urandom)};
            wr(DWD_SEL_SPEC, d, {4'($urandom), 4'($urandom % 10)});
        end
        $display("test step done");
        wr(DWD_SEL_SPEC, DWD_SOFT_RESET, 8'h13);
        @(posedge clk_i);
        #1 ld = 1'b1;
        @(posedge clk_i);
        #1 ld = 1'b0;
        r_gnd = 1'b0;
        chk_all();
        $display("test soft_reset done");
        wr(DWD_SEL_OFFSET, 14'($urandom), 8'h00);
        @(posedge clk_i);
        #1 rst_i = 1'b1;
        repeat (2) @(posedge clk_i);
        #1 rst_i = 1'b0;
        rst_ref();
        chk_all();
        $display("test hw_reset done");
        summarize();
    end
    initial begin
        #400_000;
        bad_count++;
        summarize();
    end
endmodule
